// file: pkg/fss_pkg.sv
/*
 * fss_pkg: constants, types and the register map of the fault
 * simulation sequencer.
 * assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package fss_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ         = 10000000;
  localparam int unsigned RESET_GAP_MS   = 100;
  localparam int unsigned REARM_S        = 5;
  localparam int unsigned RESET_GAP_CYC  = RESET_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned REARM_CYC      = REARM_S * CLK_HZ;
  // simulated frequency is 0.16 % above rated: ratio in 1/10000
  localparam int unsigned FREQ_UP_PPTT   = 16;
  localparam int unsigned FREQ_BASE_PPTT = 10000;

  // ************************************************************
  // register offsets (word indices, byte address = offset*4)
  // ************************************************************
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_CMD     = 5'h01;
  localparam logic [4:0] REG_PRE_T   = 5'h02;
  localparam logic [4:0] REG_FLT_T   = 5'h03;
  localparam logic [4:0] REG_POST_T  = 5'h04;
  localparam logic [4:0] REG_STATE   = 5'h05;
  localparam logic [4:0] REG_IRQ_ST  = 5'h06;
  localparam logic [4:0] REG_IRQ_MSK = 5'h07;
  localparam logic [4:0] REG_INOM    = 5'h08;
  localparam logic [4:0] REG_FRATED  = 5'h09;
  localparam logic [4:0] REG_SIMFREQ = 5'h0A;
  localparam logic [4:0] REG_QTY0    = 5'h10; // 16 simulated quantities
  localparam int unsigned N_QTY      = 16;

  // CTRL fields
  localparam int unsigned CTRL_INUSE  = 0;
  localparam int unsigned CTRL_TRIPEN = 1;
  localparam int unsigned CTRL_FPEN   = 2;
  localparam int unsigned CTRL_XSEN   = 3;
  // CMD fields (write-only pulses)
  localparam int unsigned CMD_START   = 0;
  localparam int unsigned CMD_STOP    = 1;
  // event bits
  localparam int unsigned EV_START    = 0;
  localparam int unsigned EV_DONE     = 1;
  localparam int unsigned EV_ABORT    = 2;
  localparam int unsigned EV_STOP     = 3;
  localparam int unsigned EV_FORCE    = 4;
  localparam int unsigned N_EV        = 5;

  localparam logic [31:0] PRE_T_RST   = 32'h0000_2710;
  localparam logic [31:0] INOM_RST    = 32'h0000_03E8;
  localparam logic [31:0] FRATED_RST  = 32'h0000_C350;

  // reported state codes
  localparam logic [2:0] CODE_NORMAL = 3'h0;
  localparam logic [2:0] CODE_PRE    = 3'h1;
  localparam logic [2:0] CODE_FAULT  = 3'h2;
  localparam logic [2:0] CODE_POST   = 3'h3;
  localparam logic [2:0] CODE_RESET  = 3'h4;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [5:0] {
    FSS_IDLE  = 6'h01,
    FSS_RSTA  = 6'h02,
    FSS_PRE   = 6'h04,
    FSS_FAULT = 6'h08,
    FSS_POST  = 6'h10,
    FSS_RSTB  = 6'h20
  } fss_state_t;

  // real phase current magnitudes
  typedef struct packed {
    logic [15:0] ia;
    logic [15:0] ib;
    logic [15:0] ic;
  } fss_iphase_t;

  // outputs toward protection functions and recorders
  typedef struct packed {
    logic [2:0]  stateCode;
    logic        simActive;
    logic        protDisable;
    logic        energyFreeze;
    logic        phaseNeutral;
  } fss_status_t;

endpackage : fss_pkg

// file: design/fss_sequencer.sv
/*
 * fss_sequencer: fault simulation sequencer with Avalon-MM registers.
 * assumes external inputs are asynchronous pins (three
 * flip-flops), phase currents and trip decisions come from logic on
 * clk_sys.
 */
//
// Function
// RULE1: run order pre-fault, fault, post-fault
// RULE2: 100 ms reset gap before and after
// RULE3: report state code 0 to 4
// RULE4: phase durations and quantities from settings
// RULE5: abort when phase current above 0.1 In
// RULE6: restart only after 5 s below limit
// RULE7: either block input stops simulator
// RULE8: force-post jumps pre/fault to post
// RULE9: energy counters frozen while running
// RULE10: simulated frequency 0.16 % above rated
// RULE11: no-trip setting blocks trip command
// RULE12: with-trip setting passes trip command
// RULE13: manual start runs whole cycle
// RULE14: manual stop returns to normal at once
// RULE15: external start unless blocked or forbidden
// RULE16: simulated voltages are phase-to-neutral
// RULE17: works only when set in use
// RULE18: end, abort, stop restore normal operation
// RULE19: starts ignored while running
`timescale 1ns/1ps
module fss_sequencer
  import fss_pkg::*;
#(
  parameter int unsigned RESET_CYC = RESET_GAP_CYC,
  parameter int unsigned REARM_CNT = REARM_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // external pins
  input  wire logic        ext_block_a,
  input  wire logic        ext_block_b,
  input  wire logic        force_post_fault_in,
  input  wire logic        ext_sim_start,
  // measurement and protection side
  input  wire fss_iphase_t realCurrent,
  input  wire logic        tripDecision,
  output logic             trip_command,
  output fss_status_t      status,
  output logic [31:0]      simFreq,
  output logic [15:0]      simQty [N_QTY],
  // interrupt
  output logic             irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    fss_state_t  st;
    logic [31:0] cnt;          // phase timer
    logic [31:0] rearm;        // quiet-current timer
    logic        ocLock;       // start refused after abort
    logic [3:0]  ctrl;
    logic [31:0] preT;
    logic [31:0] fltT;
    logic [31:0] postT;
    logic [15:0] inom;
    logic [31:0] fRated;
    logic [N_EV-1:0] irqSt;
    logic [N_EV-1:0] irqMsk;
    logic [31:0] rdata;
    logic        ack;
    logic [2:0]  syBlkA, syBlkB, syFp, syXs; // three-stage syncs
    logic        xsPrev;
    logic        fpPrev;
  } fss_regs_t;

  fss_regs_t   s_r;                 // registered state
  fss_regs_t   s_nxt;               // next state
  logic [15:0] qty_r [N_QTY];       // simulated quantities
  logic [15:0] qty_nxt [N_QTY];

  // ************************************************************
  // helpers
  // ************************************************************
  // current above a tenth of nominal (10*i > inom)
  function automatic logic overLimit(input logic [15:0] i,
                                     input logic [15:0] n);
    // 10*i built as 8*i + 2*i, all terms 20 bits wide
    overLimit = (({1'h0, i, 3'h0} + {3'h0, i, 1'h0}) > {4'h0, n});
  endfunction : overLimit

  // phase duration in cycles, at least one
  function automatic logic [31:0] durOf(input logic [31:0] t);
    durOf = (t == 32'h0) ? 32'h1 : t;
  endfunction : durOf

  logic wrHit, rdHit, anyOver, blocked, startReq, fpRise, xsRise;
  logic running;

  // a write lands at the edge where waitrequest is seen low
  assign wrHit   = avs_write && s_r.ack;
  assign rdHit   = avs_read && !s_r.ack;
  assign anyOver = overLimit(realCurrent.ia, s_r.inom) ||
                   overLimit(realCurrent.ib, s_r.inom) ||
                   overLimit(realCurrent.ic, s_r.inom);
  // agreeing second and third stages count as the pin level
  assign blocked = (s_r.syBlkA[1] & s_r.syBlkA[2]) |
                   (s_r.syBlkB[1] & s_r.syBlkB[2]);      // RULE7
  assign xsRise  = (s_r.syXs[1] & s_r.syXs[2]) & !s_r.xsPrev;
  assign fpRise  = (s_r.syFp[1] & s_r.syFp[2]) & !s_r.fpPrev;
  assign running = (s_r.st != FSS_IDLE);

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    s_nxt   = s_r;
    qty_nxt = qty_r;
    // pin synchronisers
    s_nxt.syBlkA = {s_r.syBlkA[1:0], ext_block_a};
    s_nxt.syBlkB = {s_r.syBlkB[1:0], ext_block_b};
    s_nxt.syFp   = {s_r.syFp[1:0], force_post_fault_in};
    s_nxt.syXs   = {s_r.syXs[1:0], ext_sim_start};
    s_nxt.xsPrev = s_r.syXs[1] & s_r.syXs[2];
    s_nxt.fpPrev = s_r.syFp[1] & s_r.syFp[2];
    // bus: one wait cycle, then answer
    s_nxt.ack = (avs_read || avs_write) && !s_r.ack;
    if (rdHit) begin
      unique case (avs_address[6:2])
        REG_CTRL:    s_nxt.rdata = {28'h0, s_r.ctrl};
        REG_PRE_T:   s_nxt.rdata = s_r.preT;
        REG_FLT_T:   s_nxt.rdata = s_r.fltT;
        REG_POST_T:  s_nxt.rdata = s_r.postT;
        REG_STATE:   s_nxt.rdata = {26'h0, s_r.ocLock, blocked,
                                    1'h0, status.stateCode};
        REG_IRQ_ST:  s_nxt.rdata = {27'h0, s_r.irqSt};
        REG_IRQ_MSK: s_nxt.rdata = {27'h0, s_r.irqMsk};
        REG_INOM:    s_nxt.rdata = {16'h0, s_r.inom};
        REG_FRATED:  s_nxt.rdata = s_r.fRated;
        REG_SIMFREQ: s_nxt.rdata = simFreq;
        default: begin
          // quantity window, otherwise unmapped reads zero
          if (avs_address[6]) s_nxt.rdata = {16'h0, qty_r[avs_address[5:2]]};
          else s_nxt.rdata = 32'h0;
        end
      endcase
    end
    startReq = 1'b0;
    if (wrHit) begin
      unique case (avs_address[6:2])
        REG_CTRL:    s_nxt.ctrl   = avs_writedata[3:0];
        REG_CMD: begin
          startReq = avs_writedata[CMD_START];
        end
        REG_PRE_T:   s_nxt.preT   = avs_writedata;            // RULE4
        REG_FLT_T:   s_nxt.fltT   = avs_writedata;            // RULE4
        REG_POST_T:  s_nxt.postT  = avs_writedata;            // RULE4
        REG_IRQ_ST:  s_nxt.irqSt  = s_r.irqSt & ~avs_writedata[N_EV-1:0];
        REG_IRQ_MSK: s_nxt.irqMsk = avs_writedata[N_EV-1:0];
        REG_INOM:    s_nxt.inom   = avs_writedata[15:0];
        REG_FRATED:  s_nxt.fRated = avs_writedata;
        default: begin
          if (avs_address[6]) qty_nxt[avs_address[5:2]] = avs_writedata[15:0];
        end
      endcase
    end
    // external start counts only when assigned
    if (s_r.ctrl[CTRL_XSEN] && xsRise) startReq = 1'b1;       // RULE15
    // quiet-current timer for restart
    if (anyOver) begin
      s_nxt.rearm = 32'h0;
    end else if (s_r.ocLock) begin
      if (s_r.rearm >= REARM_CNT - 1) s_nxt.ocLock = 1'b0;     // RULE6
      else s_nxt.rearm = s_r.rearm + 32'h1;
    end
    // sequencer
    s_nxt.cnt = s_r.cnt + 32'h1;
    unique case (s_r.st)
      FSS_IDLE: begin
        s_nxt.cnt = 32'h0;
        // refused when not in use, blocked or after abort; starts
        // outside idle are never looked at
        // RULE19
        if (startReq && s_r.ctrl[CTRL_INUSE] && !blocked &&
            !s_r.ocLock && !anyOver) begin                   // RULE17 RULE15
          s_nxt.st = FSS_RSTA;                               // RULE2
          s_nxt.irqSt[EV_START] = 1'b1;
        end
      end
      FSS_RSTA: if (s_r.cnt >= RESET_CYC - 1) begin
        s_nxt.st  = FSS_PRE;                                 // RULE1
        s_nxt.cnt = 32'h0;
      end
      FSS_PRE: if (s_r.cnt >= durOf(s_r.preT) - 1) begin
        s_nxt.st  = FSS_FAULT;                               // RULE1
        s_nxt.cnt = 32'h0;
      end
      FSS_FAULT: if (s_r.cnt >= durOf(s_r.fltT) - 1) begin
        s_nxt.st  = FSS_POST;                                // RULE1 RULE13
        s_nxt.cnt = 32'h0;
      end
      FSS_POST: if (s_r.cnt >= durOf(s_r.postT) - 1) begin
        s_nxt.st  = FSS_RSTB;                                // RULE2
        s_nxt.cnt = 32'h0;
      end
      FSS_RSTB: if (s_r.cnt >= RESET_CYC - 1) begin
        s_nxt.st  = FSS_IDLE;                                // RULE18
        s_nxt.irqSt[EV_DONE] = 1'b1;
      end
    endcase
    // force-post from pre-fault or fault
    if ((s_r.st == FSS_PRE || s_r.st == FSS_FAULT) &&
        s_r.ctrl[CTRL_FPEN] && fpRise) begin
      s_nxt.st  = FSS_POST;                                  // RULE8
      s_nxt.cnt = 32'h0;
      s_nxt.irqSt[EV_FORCE] = 1'b1;
    end
    // manual stop and blocks end at once
    if (running && ((wrHit && avs_address[6:2] == REG_CMD &&
        avs_writedata[CMD_STOP]) || blocked ||
        !s_r.ctrl[CTRL_INUSE])) begin
      s_nxt.st = FSS_IDLE;                                   // RULE14 RULE7
      s_nxt.irqSt[EV_STOP] = 1'b1;
    end
    // overcurrent abort has the last word
    if (running && anyOver) begin
      s_nxt.st     = FSS_IDLE;                               // RULE5 RULE18
      s_nxt.ocLock = 1'b1;
      s_nxt.rearm  = 32'h0;
      s_nxt.irqSt[EV_ABORT] = 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_r        <= '0;
      s_r.st     <= FSS_IDLE;
      s_r.preT   <= PRE_T_RST;
      s_r.fltT   <= PRE_T_RST;
      s_r.postT  <= PRE_T_RST;
      s_r.inom   <= INOM_RST[15:0];
      s_r.fRated <= FRATED_RST;
      for (int k = 0; k < N_QTY; k++) qty_r[k] <= 16'h0;
    end else begin
      s_r   <= s_nxt;
      qty_r <= qty_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    unique case (s_r.st)
      FSS_IDLE:  status.stateCode = CODE_NORMAL;             // RULE3
      FSS_PRE:   status.stateCode = CODE_PRE;
      FSS_FAULT: status.stateCode = CODE_FAULT;
      FSS_POST:  status.stateCode = CODE_POST;
      default:   status.stateCode = CODE_RESET;
    endcase
  end
  assign status.simActive    = running;                       // RULE18
  assign status.protDisable  = (s_r.st == FSS_RSTA) ||
                               (s_r.st == FSS_RSTB);          // RULE2
  assign status.energyFreeze = running;                       // RULE9
  assign status.phaseNeutral = 1'b1;                          // RULE16
  // trip passes outside simulation or in the with-trip setting
  assign trip_command = tripDecision &&
                        (!running || s_r.ctrl[CTRL_TRIPEN]);  // RULE11 RULE12
  assign simFreq = s_r.fRated + (s_r.fRated * FREQ_UP_PPTT)
                   / FREQ_BASE_PPTT;                          // RULE10
  assign simQty  = qty_r;                                     // RULE4
  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;
  assign irq = |(s_r.irqSt & s_r.irqMsk);

  // ************************************************************
  // assertions
  // ************************************************************
  property p_order;
    @(posedge clk_sys) disable iff (!reset_n)
    (s_r.st == FSS_FAULT) |-> $past(s_r.st) inside {FSS_PRE, FSS_FAULT};
  endproperty
  a_order: assert property (p_order) else $error("bad order"); // RULE1
  property p_gap;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(s_r.st == FSS_PRE) |-> $past(s_r.st) == FSS_RSTA;
  endproperty
  a_gap: assert property (p_gap) else $error("no reset gap"); // RULE2
  property p_code;
    @(posedge clk_sys) disable iff (!reset_n)
    !running |-> status.stateCode == CODE_NORMAL;
  endproperty
  a_code: assert property (p_code) else $error("bad code"); // RULE3
  property p_abort;
    @(posedge clk_sys) disable iff (!reset_n)
    (running && anyOver) |=> !running && s_r.ocLock;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort"); // RULE5
  property p_block;
    @(posedge clk_sys) disable iff (!reset_n)
    blocked |=> !running;
  endproperty
  a_block: assert property (p_block) else $error("ran blocked"); // RULE7
  property p_freeze;
    @(posedge clk_sys) disable iff (!reset_n)
    running |-> status.energyFreeze;
  endproperty
  a_freeze: assert property (p_freeze) else $error("no freeze"); // RULE9
  property p_trip;
    @(posedge clk_sys) disable iff (!reset_n)
    (running && !s_r.ctrl[CTRL_TRIPEN]) |-> !trip_command;
  endproperty
  a_trip: assert property (p_trip) else $error("trip leaked"); // RULE11
  property p_lock;
    @(posedge clk_sys) disable iff (!reset_n)
    (s_r.ocLock && !running) |=> !running;
  endproperty
  a_lock: assert property (p_lock) else $error("start in lock"); // RULE6
  c_run:   cover property (@(posedge clk_sys) $rose(s_r.st == FSS_RSTB));
  c_abort: cover property (@(posedge clk_sys) $rose(s_r.ocLock));
  c_force: cover property (@(posedge clk_sys) $rose(s_r.irqSt[EV_FORCE]));

endmodule : fss_sequencer

// file: test/fss_partner.sv
/*
 * fss_partner: protection side seen by the fault simulation sequencer.
 * assumes status comes from the sequencer on clk_sys; the bench decides
 * when a real overcurrent is present.
 */
`timescale 1ns/1ps
module fss_partner
  import fss_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // sequencer status and bench control
  input  wire fss_status_t status,
  input  wire logic        overCurrent,
  // measured currents and trip decision
  output fss_iphase_t      realCurrent,
  output logic             tripDecision
);
  logic [1:0] faultAge_r;  // cycles spent in the fault code, saturating

  // protection decides to trip a few cycles into the fault phase
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      faultAge_r <= 2'h0;
    end else if (status.stateCode != CODE_FAULT) begin
      faultAge_r <= 2'h0;
    end else if (faultAge_r != 2'h3) begin
      faultAge_r <= faultAge_r + 2'h1;
    end
  end
  assign tripDecision = (faultAge_r == 2'h3);
  // 101 against a nominal of 1000 sits just above one tenth
  assign realCurrent  = overCurrent ? {16'h0000, 16'h0065, 16'h0000} : '0;
endmodule : fss_partner

// file: test/fss_sequencer_tb_top.sv
/*
 * fss_sequencer_tb_top: self-checking bench of the sequencer.
 * assumes shortened reset gap (8) and re-arm delay (20) cycles.
 */
`timescale 1ns/1ps
module fss_sequencer_tb_top
  import fss_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  logic        clk_sys, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [6:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, simFreq;
  logic        ext_block_a, ext_block_b, force_post_fault_in;
  logic        ext_sim_start, tripDecision, trip_command, irq, overCurrent;
  fss_iphase_t realCurrent;
  fss_status_t status;
  logic [15:0] simQty [N_QTY];
  logic [2:0]  codeLog [$];  // state codes in order of appearance
  logic [2:0]  lastCode;
  int          errTotal, testsRun, cyc;

  fss_sequencer #(.RESET_CYC(8), .REARM_CNT(20)) fss_sequencer_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_block_a(ext_block_a),
    .ext_block_b(ext_block_b), .force_post_fault_in(force_post_fault_in),
    .ext_sim_start(ext_sim_start), .realCurrent(realCurrent),
    .tripDecision(tripDecision), .trip_command(trip_command),
    .status(status), .simFreq(simFreq), .simQty(simQty), .irq(irq));

  fss_partner fss_partner_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .status(status),
    .overCurrent(overCurrent), .realCurrent(realCurrent),
    .tripDecision(tripDecision));

  // ************************************************************
  // clock, code monitor and hang guard
  // ************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (status.stateCode !== lastCode) codeLog.push_back(status.stateCode);
    lastCode = status.stateCode;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      errTotal++;
      finishTest();
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic finishTest();
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finishTest

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      errTotal++;
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] w,
                     input logic [31:0] d, output logic [31:0] q);
    logic busy;
    @(posedge clk_sys);
    avs_address   <= {w, 2'b00};
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do begin
      @(negedge clk_sys);
      busy = avs_waitrequest;
      q    = avs_readdata;
      @(posedge clk_sys);
    end while (busy);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] w, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, w, d, q);
  endtask : wr

  task automatic rdChk(input string nm, input logic [4:0] w, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, w, 32'h0, q);
    chk(nm, e, q);
  endtask : rdChk

  // wait a bounded number of cycles for a state code
  task automatic waitCode(input logic [2:0] c, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (status.stateCode !== c && n < lim);
    chk("stateCode", {29'h0, c}, {29'h0, status.stateCode});
    @(posedge clk_sys);
  endtask : waitCode

  // the code must stay put for a number of cycles
  task automatic holdCode(input logic [2:0] c, input int len);
    repeat (len) begin
      @(negedge clk_sys);
      chk("heldCode", {29'h0, c}, {29'h0, status.stateCode});
    end
    @(posedge clk_sys);
  endtask : holdCode

  // a whole cycle with a second start thrown in during the fault
  task automatic runFull(input logic tripEn);
    codeLog.delete();
    wr(REG_CMD, 32'h1);
    waitCode(CODE_RESET, 10);
    chk("protDisable", 32'h1, {31'h0, status.protDisable});
    waitCode(CODE_FAULT, 80);
    repeat (5) @(negedge clk_sys);
    chk("trip_command", {31'h0, tripEn}, {31'h0, trip_command});
    chk("energyFreeze", 32'h1, {31'h0, status.energyFreeze});
    chk("phaseNeutral", 32'h1, {31'h0, status.phaseNeutral});
    wr(REG_CMD, 32'h1);
    waitCode(CODE_NORMAL, 200);
    chk("logLength", 32'h6, codeLog.size());
    foreach (codeLog[k]) begin
      chk("codeOrder", {29'h0, k == 0 ? CODE_RESET : k == 1 ? CODE_PRE :
        k == 2 ? CODE_FAULT : k == 3 ? CODE_POST : k == 4 ? CODE_RESET :
        CODE_NORMAL}, {29'h0, codeLog[k]});
    end
  endtask : runFull

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    reset_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {ext_block_a, ext_block_b, force_post_fault_in, ext_sim_start} = '0;
    {overCurrent, errTotal, testsRun, cyc} = '0;
    lastCode = CODE_NORMAL;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdChk("preTime", REG_PRE_T, PRE_T_RST);
    rdChk("nominal", REG_INOM, INOM_RST);
    rdChk("simFreqReg", REG_SIMFREQ, 32'h0000_C3A0);
    chk("simFreq", 32'h0000_C3A0, simFreq);
    rdChk("unmapped", 5'h0B, 32'h0);
    wr(REG_QTY0, 32'h0000_1234);
    rdChk("quantity", REG_QTY0, 32'h0000_1234);
    wr(REG_PRE_T, 32'h28);
    wr(REG_FLT_T, 32'h28);
    wr(REG_POST_T, 32'h28);
    wr(REG_CMD, 32'h1);
    holdCode(CODE_NORMAL, 10);
    wr(REG_CTRL, 32'h1);
    runFull(1'b0);
    wr(REG_CTRL, 32'h3);
    runFull(1'b1);
    // stop mid-run with the stop event unmasked
    wr(REG_IRQ_MSK, 32'h8);
    wr(REG_CMD, 32'h1);
    waitCode(CODE_PRE, 20);
    wr(REG_CMD, 32'h2);
    waitCode(CODE_NORMAL, 3);
    chk("energyFreezeOff", 32'h0, {31'h0, status.energyFreeze});
    chk("irqSet", 32'h1, {31'h0, irq});
    wr(REG_IRQ_ST, 32'h8);
    @(negedge clk_sys);
    chk("irqClear", 32'h0, {31'h0, irq});
    // force-post jumps out of pre-fault
    wr(REG_CTRL, 32'h5);
    wr(REG_CMD, 32'h1);
    waitCode(CODE_PRE, 20);
    force_post_fault_in <= 1'b1;
    waitCode(CODE_POST, 8);
    force_post_fault_in <= 1'b0;
    waitCode(CODE_NORMAL, 80);
    // blocking refuses a start and stops a run
    ext_block_a <= 1'b1;
    repeat (5) @(posedge clk_sys);
    wr(REG_CMD, 32'h1);
    holdCode(CODE_NORMAL, 10);
    ext_block_a <= 1'b0;
    wr(REG_CMD, 32'h1);
    waitCode(CODE_PRE, 20);
    ext_block_b <= 1'b1;
    waitCode(CODE_NORMAL, 8);
    ext_block_b <= 1'b0;
    // overcurrent abort, then the re-arm delay
    wr(REG_CMD, 32'h1);
    waitCode(CODE_PRE, 20);
    overCurrent <= 1'b1;
    waitCode(CODE_NORMAL, 4);
    overCurrent <= 1'b0;
    wr(REG_CMD, 32'h1);
    holdCode(CODE_NORMAL, 6);
    repeat (30) @(posedge clk_sys);
    wr(REG_CMD, 32'h1);
    waitCode(CODE_RESET, 8);
    wr(REG_CMD, 32'h2);
    waitCode(CODE_NORMAL, 4);
    // external start, refused while blocked
    wr(REG_CTRL, 32'h9);
    ext_block_b         <= 1'b1;
    ext_sim_start       <= 1'b1;
    holdCode(CODE_NORMAL, 10);
    ext_sim_start       <= 1'b0;
    ext_block_b         <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ext_sim_start <= 1'b1;
    waitCode(CODE_RESET, 10);
    ext_sim_start <= 1'b0;
    waitCode(CODE_NORMAL, 200);
    finishTest();
  end
endmodule : fss_sequencer_tb_top
